// [pkg/tcp_pkg.sv]
// package of constants and types for the timer/counter/pwm unit
// What this block does
// - counter is 16-bit, counts down only
// - counting clock picked from several sources
// - comparator modes LT, LTE, EQ, GTE, GT
// - period loads on start, reset, terminal count
// - interrupt on tc, compare or capture, selectable
// - run modes: free, one shot, enable gated
// - one shot stops at end, no reload
// - gated mode counts only while enable high
// - drives compare, complement, tc and interrupt
// - complementary outputs separated by dead band
// - kill forces pwm outputs inactive
// - capture stores full count, flags event
package tcp_pkg;

   // ****************************************
   // bus geometry
   // ****************************************
   localparam int TCP_AW = 5;
   localparam int TCP_DW = 32;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [TCP_AW-1:0] TCP_A_CTRL   = 5'h00;
   localparam logic [TCP_AW-1:0] TCP_A_PERIOD = 5'h04;
   localparam logic [TCP_AW-1:0] TCP_A_CMP    = 5'h08;
   localparam logic [TCP_AW-1:0] TCP_A_DEAD   = 5'h0C;
   localparam logic [TCP_AW-1:0] TCP_A_COUNT  = 5'h10;
   localparam logic [TCP_AW-1:0] TCP_A_CAPT   = 5'h14;
   localparam logic [TCP_AW-1:0] TCP_A_STAT   = 5'h18;

   // ****************************************
   // widths and reset values
   // ****************************************
   localparam int              TCP_CNT_W      = 16;
   localparam int              TCP_DB_W       = 8;
   localparam int              TCP_N_SRC      = 3;
   localparam logic [15:0]     TCP_PERIOD_RST = 16'hFFFF;
   localparam logic [15:0]     TCP_CMP_RST    = 16'h8000;
   localparam logic [7:0]      TCP_DEAD_RST   = 8'h00;
   localparam logic [1:0]      TCP_SEL_SYS    = 2'h0;

   // ****************************************
   // modes and states
   // ****************************************
   typedef enum logic [1:0] {MODE_FREE, MODE_ONESHOT, MODE_GATED} tcp_mode_t;
   typedef enum logic [2:0] {CMP_LT, CMP_LTE, CMP_EQ, CMP_GTE, CMP_GT} tcp_cmp_t;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} tcp_state_t;

   // control word, bit 0 is run
   typedef struct packed {
      logic [2:0] irq_mask;   // {capture, compare, tc}
      logic [1:0] clk_sel;    // 0 = system clock, k = source k-1
      logic       comp_en;    // complementary output enable
      tcp_cmp_t   cmp_mode;
      logic       cap_en;
      tcp_mode_t  mode;
      logic       run;
   } tcp_ctrl_t;
   localparam int TCP_CTRL_W = $bits(tcp_ctrl_t);

   // event / status word, tc in bit 0
   typedef struct packed {
      logic cap;
      logic cmp;
      logic tc;
   } tcp_ev_t;
   localparam int TCP_EV_W = $bits(tcp_ev_t);

endpackage

// [design/tcp_tick_sel.sv]
// clock source selector producing a one-cycle counting tick
`timescale 1ns/1ns
module tcp_tick_sel #(
   parameter int N_SRC = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             ce,
   // selection
   input  wire logic [1:0]       sel,
   input  wire logic [N_SRC-1:0] src_in,
   // result
   output logic                  tick
);
   import tcp_pkg::*;

   logic [N_SRC-1:0] prev_reg;
   wire  [N_SRC-1:0] edges = src_in & ~prev_reg;
   wire  [1:0]       idx   = sel - 2'h1;
   wire              valid = (int'(idx) < N_SRC);

   if (N_SRC < 1 || N_SRC > 3) begin : g_chk
      $error("tcp_tick_sel: N_SRC must be 1..3");
   end

   // sources are synchronous levels; a rising edge is one tick
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         prev_reg <= '0;
      else if (ce)
         prev_reg <= src_in;
   end

   // out-of-range selection gives no tick rather than aliasing
   assign tick = (sel == TCP_SEL_SYS) ? 1'b1 : (valid & edges[idx]);

   a_sys_tick: assert property (@(posedge clk) disable iff (!rstn)
      (sel == TCP_SEL_SYS) |-> tick)
      else $error("system clock selection gave no tick");
endmodule

// [design/tcp_deadband.sv]
// dead band generator for complementary pwm outputs with kill
`timescale 1ns/1ns
module tcp_deadband #(
   parameter int DB_W = 8
) (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rstn,
   input  wire logic            ce,
   // control
   input  wire logic            raw,
   input  wire logic [DB_W-1:0] dead,
   input  wire logic            comp_en,
   input  wire logic            kill,
   // outputs
   output logic                 out_p,
   output logic                 out_n
);
   logic            last_reg;
   logic [DB_W-1:0] cnt_reg;
   wire             change = (raw != last_reg);
   wire             quiet  = (cnt_reg == '0);

   // every change drops both sides, then waits dead cycles
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last_reg <= 1'b0;
         cnt_reg  <= '0;
      end else if (ce) begin
         last_reg <= raw;
         cnt_reg  <= change ? dead : (quiet ? cnt_reg : cnt_reg - 1'b1);
      end
   end

   // outputs are flops; kill wins over everything
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_p <= 1'b0;
         out_n <= 1'b0;
      end else if (ce) begin
         out_p <= ~kill & ~change & quiet & last_reg;
         out_n <= ~kill & ~change & quiet & ~last_reg & comp_en;
      end
   end

   a_kill_forces: assert property (@(posedge clk) disable iff (!rstn)
      (kill && ce) |=> (!out_p && !out_n))
      else $error("kill did not force outputs inactive");
   a_never_both: assert property (@(posedge clk) disable iff (!rstn)
      !(out_p && out_n))
      else $error("both pwm outputs active together");
endmodule

// [design/tcp_unit.sv]
// timer/counter/pwm unit with register port
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module tcp_unit #(
   parameter int CNT_W = tcp_pkg::TCP_CNT_W,
   parameter int DB_W  = tcp_pkg::TCP_DB_W,
   parameter int N_SRC = tcp_pkg::TCP_N_SRC
) (
   // clock, reset, enable
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic                      ce,
   // register port
   input  wire logic [tcp_pkg::TCP_AW-1:0] addr,
   input  wire logic [tcp_pkg::TCP_DW-1:0] wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   output logic      [tcp_pkg::TCP_DW-1:0] rdata,
   // routed control inputs
   input  wire logic [N_SRC-1:0]          clk_src,
   input  wire logic                      ext_enable,
   input  wire logic                      ext_reset,
   input  wire logic                      ext_capture,
   input  wire logic                      ext_kill,
   // routed outputs
   output logic                           cmp_out,
   output logic                           cmp_n_out,
   output logic                           tc_out,
   output logic                           irq_req
);
   import tcp_pkg::*;

   // ****************************************
   // elaboration checks
   // ****************************************
   if (CNT_W < 2 || CNT_W > TCP_DW) begin : g_chk_cnt
      $error("tcp_unit: CNT_W must be 2..32");
   end
   if (DB_W < 1 || DB_W > TCP_DW) begin : g_chk_db
      $error("tcp_unit: DB_W must be 1..32");
   end
   // the selector decodes at most three routed sources
   if (N_SRC < 1 || N_SRC > 3) begin : g_chk_src
      $error("tcp_unit: N_SRC must be 1..3");
   end

   // ****************************************
   // registers
   // ****************************************
   tcp_ctrl_t         ctrl_reg;
   logic [CNT_W-1:0]  period_reg;
   logic [CNT_W-1:0]  cmpv_reg;
   logic [DB_W-1:0]   dead_reg;
   logic [CNT_W-1:0]  count_reg;
   logic [CNT_W-1:0]  count_next;
   logic [CNT_W-1:0]  capt_reg;
   tcp_ev_t           stat_reg;
   tcp_ev_t           stat_next;
   tcp_state_t        state_reg;
   tcp_state_t        state_next;
   logic              run_d_reg;
   logic              capin_d_reg;
   logic              cmp_d_reg;
   logic              tc_reg;
   logic              irq_reg;
   logic [TCP_DW-1:0] rdata_reg;
   logic              cmp_raw;
   logic              tick;

   // ****************************************
   // register port decode
   // ****************************************
   wire wr_ctrl   = wr && (addr == TCP_A_CTRL);
   wire wr_period = wr && (addr == TCP_A_PERIOD);
   wire wr_cmp    = wr && (addr == TCP_A_CMP);
   wire wr_dead   = wr && (addr == TCP_A_DEAD);
   wire wr_stat   = wr && (addr == TCP_A_STAT);

   // ****************************************
   // clock source selection
   // ****************************************
   tcp_tick_sel #(
      .N_SRC (N_SRC)
   ) u_tick (
      .clk    (clk),
      .rstn   (rstn),
      .ce     (ce),
      .sel    (ctrl_reg.clk_sel),
      .src_in (clk_src),
      .tick   (tick)
   );

   // ****************************************
   // counter control decode
   // ****************************************
   // start is the software run bit going from 0 to 1
   wire run_rise = ctrl_reg.run & ~run_d_reg;
   wire load     = run_rise | ext_reset;
   wire gate_ok  = (ctrl_reg.mode != MODE_GATED) | ext_enable;
   wire step     = tick & (state_reg == ST_RUN) & gate_ok & ~load;
   wire at_zero  = (count_reg == '0);
   wire at_one   = (count_reg == CNT_W'(1));
   wire oneshot  = (ctrl_reg.mode == MODE_ONESHOT);
   wire tc_ev    = step & at_one;

   // next count: load, reload after zero, or decrement only
   always_comb begin
      count_next = count_reg;
      if (load)
         count_next = period_reg;
      else if (step && at_zero && !oneshot)
         count_next = period_reg;
      else if (step && !at_zero)
         count_next = count_reg - CNT_W'(1);
   end

   // run state: one shot parks in halt until a new start or reset
   always_comb begin
      case (state_reg)
         ST_IDLE:
            state_next = (ctrl_reg.run && load) ? ST_RUN : ST_IDLE;
         ST_RUN:
            state_next = (step && at_zero && oneshot) ? ST_HALT : ST_RUN;
         ST_HALT:
            state_next = load ? ST_RUN : ST_HALT;
         default:
            state_next = ST_IDLE;
      endcase
      if (!ctrl_reg.run)
         state_next = ST_IDLE;
   end

   // ****************************************
   // comparator
   // ****************************************
   // unused mode codes read as never true so cmp_out stays low
   always_comb begin
      case (ctrl_reg.cmp_mode)
         CMP_LT:  cmp_raw = (count_reg <  cmpv_reg);
         CMP_LTE: cmp_raw = (count_reg <= cmpv_reg);
         CMP_EQ:  cmp_raw = (count_reg == cmpv_reg);
         CMP_GTE: cmp_raw = (count_reg >= cmpv_reg);
         CMP_GT:  cmp_raw = (count_reg >  cmpv_reg);
         default: cmp_raw = 1'b0;
      endcase
   end

   // ****************************************
   // events and status
   // ****************************************
   wire     cap_fire = ctrl_reg.cap_en & ext_capture & ~capin_d_reg;
   wire     cmp_rise = cmp_raw & ~cmp_d_reg;
   tcp_ev_t events;
   tcp_ev_t stat_clr;
   assign events   = '{cap: cap_fire, cmp: cmp_rise, tc: tc_ev};
   assign stat_clr = wr_stat ? tcp_ev_t'(wdata[TCP_EV_W-1:0]) : '0;
   // write one to clear; an event in the same cycle wins
   assign stat_next = (stat_reg & ~stat_clr) | events;

   // ****************************************
   // read mux
   // ****************************************
   // narrow values zero extended; unmapped offsets read zero
   wire [TCP_DW-1:0] rd_ctrl   = TCP_DW'(ctrl_reg);
   wire [TCP_DW-1:0] rd_period = TCP_DW'(period_reg);
   wire [TCP_DW-1:0] rd_cmp    = TCP_DW'(cmpv_reg);
   wire [TCP_DW-1:0] rd_dead   = TCP_DW'(dead_reg);
   wire [TCP_DW-1:0] rd_count  = TCP_DW'(count_reg);
   wire [TCP_DW-1:0] rd_capt   = TCP_DW'(capt_reg);
   wire [TCP_DW-1:0] rd_stat   = TCP_DW'(stat_reg);
   wire [TCP_DW-1:0] rd_sel    =
      (addr == TCP_A_CTRL)   ? rd_ctrl   :
      (addr == TCP_A_PERIOD) ? rd_period :
      (addr == TCP_A_CMP)    ? rd_cmp    :
      (addr == TCP_A_DEAD)   ? rd_dead   :
      (addr == TCP_A_COUNT)  ? rd_count  :
      (addr == TCP_A_CAPT)   ? rd_capt   :
      (addr == TCP_A_STAT)   ? rd_stat   : '0;

   // ****************************************
   // software registers
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg   <= '0;
         period_reg <= CNT_W'(TCP_PERIOD_RST);
         cmpv_reg   <= CNT_W'(TCP_CMP_RST);
         dead_reg   <= DB_W'(TCP_DEAD_RST);
      end else if (ce) begin
         if (wr_ctrl)
            ctrl_reg <= tcp_ctrl_t'(wdata[TCP_CTRL_W-1:0]);
         if (wr_period)
            period_reg <= wdata[CNT_W-1:0];
         if (wr_cmp)
            cmpv_reg <= wdata[CNT_W-1:0];
         if (wr_dead)
            dead_reg <= wdata[DB_W-1:0];
      end
   end

   // ****************************************
   // counter, state and edge history
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_reg   <= CNT_W'(TCP_PERIOD_RST);
         state_reg   <= ST_IDLE;
         run_d_reg   <= 1'b0;
         capin_d_reg <= 1'b0;
         cmp_d_reg   <= 1'b0;
      end else if (ce) begin
         count_reg   <= count_next;
         state_reg   <= state_next;
         run_d_reg   <= ctrl_reg.run;
         capin_d_reg <= ext_capture;
         cmp_d_reg   <= cmp_raw;
      end
   end

   // capture keeps the full width of the live count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         capt_reg <= '0;
      else if (ce && cap_fire)
         capt_reg <= count_reg;
   end

   // ****************************************
   // status, tc and interrupt flops
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stat_reg <= '0;
         tc_reg   <= 1'b0;
         irq_reg  <= 1'b0;
      end else if (ce) begin
         stat_reg <= stat_next;
         tc_reg   <= tc_ev | (tc_reg & ~step & ~load);
         irq_reg  <= |(stat_next & tcp_ev_t'(ctrl_reg.irq_mask));
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         rdata_reg <= '0;
      else if (ce)
         rdata_reg <= rd ? rd_sel : '0;
   end

   // ****************************************
   // dead band and kill
   // ****************************************
   tcp_deadband #(
      .DB_W (DB_W)
   ) u_db (
      .clk     (clk),
      .rstn    (rstn),
      .ce      (ce),
      .raw     (cmp_raw),
      .dead    (dead_reg),
      .comp_en (ctrl_reg.comp_en),
      .kill    (ext_kill),
      .out_p   (cmp_out),
      .out_n   (cmp_n_out)
   );

   assign tc_out  = tc_reg;
   assign irq_req = irq_reg;
   assign rdata   = rdata_reg;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_step_nonzero;
      ce && step && !at_zero;
   endsequence
   sequence s_step_zero;
      ce && step && at_zero;
   endsequence
   sequence s_step_one;
      ce && step && at_one;
   endsequence
   sequence s_start;
      ce && run_rise;
   endsequence

   a_count_down: assert property (s_step_nonzero |=>
      count_reg == $past(count_reg) - CNT_W'(1))
      else $error("counter did not step down by one");
   a_reset_reload: assert property ((ce && ext_reset) |=>
      count_reg == $past(period_reg))
      else $error("reset input did not load the period");
   a_tc_reload: assert property ((s_step_zero and (!oneshot && !wr_period)) |=>
      count_reg == period_reg)
      else $error("terminal count did not reload the period");
   a_oneshot_halt: assert property ((s_step_zero and (oneshot && ctrl_reg.run)) |=>
      (state_reg == ST_HALT) ##1 (load || !ce || $stable(count_reg)))
      else $error("one shot kept counting after its period");
   a_gated_hold: assert property ((ce && ctrl_reg.mode == MODE_GATED && !ext_enable && !load) |=>
      $stable(count_reg))
      else $error("gated counter moved with enable low");
   a_tc_pulse: assert property ((ce && tc_ev) |=> tc_out && count_reg == '0)
      else $error("terminal count not flagged at zero");
   a_capture: assert property ((ce && cap_fire) |=>
      capt_reg == $past(count_reg) && stat_reg.cap)
      else $error("capture missed count or flag");
   a_irq_mask: assert property ((ce && tc_ev && ctrl_reg.irq_mask[0]) |=> irq_req)
      else $error("enabled tc event raised no interrupt");
   a_cmp_eq: assert property ((ctrl_reg.cmp_mode == CMP_EQ && cmp_raw) |->
      count_reg == cmpv_reg)
      else $error("equal compare true with values apart");
   a_rd_pulse: assert property ((ce && !rd) |=> rdata == '0)
      else $error("read data held without a read strobe");

   // start and terminal count steps, each checked one cycle on
   a_start_load: assert property (s_start |=>
      count_reg == $past(period_reg) && state_reg == ST_RUN)
      else $error("start did not load the period and run");
   a_tc_flag: assert property (s_step_one |=> tc_out && stat_reg.tc)
      else $error("terminal count left no flag");
   a_tc_ends: assert property ((ce && tc_out && (step || load)) |=> !tc_out)
      else $error("terminal count outlived its counting cycle");
   // outside a reload the count may only fall or hold
   a_no_up: assert property ((ce && !load && !(step && at_zero)) |=>
      count_reg <= $past(count_reg))
      else $error("counter moved upwards");
   // status is sticky and masked events reach the request line
   a_stat_sticky: assert property ((ce && stat_reg.tc && !wr_stat) |=> stat_reg.tc)
      else $error("tc status cleared without a write");
   a_cap_irq: assert property ((ce && cap_fire && ctrl_reg.irq_mask[2]) |=> irq_req)
      else $error("enabled capture event raised no interrupt");
   a_cmp_irq: assert property ((ce && cmp_rise && ctrl_reg.irq_mask[1]) |=> irq_req)
      else $error("enabled compare event raised no interrupt");
   // LT and GT modes agree with the values they compare
   a_cmp_lt: assert property ((ctrl_reg.cmp_mode == CMP_LT && cmp_raw) |->
      count_reg < cmpv_reg)
      else $error("less-than compare true with count not below");
   a_cmp_gt: assert property ((ctrl_reg.cmp_mode == CMP_GT && cmp_raw) |->
      count_reg > cmpv_reg)
      else $error("greater-than compare true with count not above");
endmodule

// [tb/tcp_fabric_model.sv]
// behavioural model of the routing fabric that feeds the timer unit
`timescale 1ns/1ns
module tcp_fabric_model (
   // clock
   input  wire logic  clk,
   // routed signals towards the unit
   output logic [2:0] clk_src,
   output logic       ext_enable,
   output logic       ext_reset,
   output logic       ext_capture,
   output logic       ext_kill
);
   // every line idles low and only moves just after a rising edge
   initial begin
      clk_src     = 3'h0;
      ext_enable  = 1'b0;
      ext_reset   = 1'b0;
      ext_capture = 1'b0;
      ext_kill    = 1'b0;
   end

   // enable is sampled high at exactly n rising edges
   task automatic enable_for(input int n);
      @(posedge clk) ext_enable <= 1'b1;
      repeat (n) @(posedge clk);
      ext_enable <= 1'b0;
   endtask

   // one-cycle pulses on the reload and capture lines
   task automatic pulse_reset;
      @(posedge clk) ext_reset <= 1'b1;
      @(posedge clk) ext_reset <= 1'b0;
   endtask

   task automatic pulse_capture;
      @(posedge clk) ext_capture <= 1'b1;
      @(posedge clk) ext_capture <= 1'b0;
   endtask

   task automatic set_kill(input logic v);
      @(posedge clk) ext_kill <= v;
   endtask

   // n rising edges on one source, high one cycle and low one cycle
   task automatic src_edges(input int k, input int n);
      repeat (n) begin
         @(posedge clk) clk_src[k] <= 1'b1;
         @(posedge clk) clk_src[k] <= 1'b0;
      end
   endtask
endmodule

// [tb/tcp_unit_test.sv]
// self-checking testbench for the timer/counter/pwm unit
`timescale 1ns/1ns
module tcp_unit_test;
   import tcp_pkg::*;

   // ****************************************
   // signals
   // ****************************************
   logic              clk, rstn, ce, wr, rd;
   logic [TCP_AW-1:0] addr;
   logic [TCP_DW-1:0] wdata, rdata;
   logic [2:0]        clk_src;
   logic              ext_enable, ext_reset, ext_capture, ext_kill;
   logic              cmp_out, cmp_n_out, tc_out, irq_req;
   int                fails, comparisons, cycles, gap;
   logic              e;

   tcp_fabric_model fab (.clk(clk), .clk_src(clk_src), .ext_enable(ext_enable), .ext_reset(ext_reset),
                         .ext_capture(ext_capture), .ext_kill(ext_kill));

   // clock enable is driven so that freezing is exercised too
   tcp_unit dut (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                 .rdata(rdata), .clk_src(clk_src), .ext_enable(ext_enable), .ext_reset(ext_reset),
                 .ext_capture(ext_capture), .ext_kill(ext_kill), .cmp_out(cmp_out),
                 .cmp_n_out(cmp_n_out), .tc_out(tc_out), .irq_req(irq_req));

   // ****************************************
   // clock, timeout and reporting
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // the full run needs about 400 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         test_done();
      end
   end

   task automatic test_done;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ****************************************
   // register bus master
   // ****************************************
   task automatic wr_reg(input logic [TCP_AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk) wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [TCP_AW-1:0] a, input logic [31:0] exp, input logic [31:0] msk);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      #1 check(rdata & msk, exp);
   endtask

   function automatic logic [31:0] ctl(input tcp_mode_t m, input tcp_cmp_t k, input logic [1:0] s,
                                      input logic [2:0] msk, input logic cap);
      tcp_ctrl_t c;
      c = '{irq_mask: msk, clk_sel: s, comp_en: 1'b1, cmp_mode: k, cap_en: cap, mode: m, run: 1'b1};
      return 32'(c);
   endfunction

   // run has to go 0 to 1 for the period to load
   task automatic start(input logic [31:0] w);
      wr_reg(TCP_A_CTRL, 32'h0);
      wr_reg(TCP_A_CTRL, w);
      repeat (3) @(posedge clk);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      check({cmp_out, cmp_n_out, tc_out, irq_req}, 32'h0);
      rd_chk(TCP_A_CTRL, 32'h0, '1);
      rd_chk(TCP_A_PERIOD, 32'h0000FFFF, '1);
      rd_chk(TCP_A_CMP, 32'h00008000, '1);
      rd_chk(TCP_A_DEAD, 32'h0, '1);
      rd_chk(TCP_A_CAPT, 32'h0, '1);
      wr_reg(TCP_A_COUNT, 32'h00001234);
      rd_chk(TCP_A_COUNT, 32'h0000FFFF, '1);
      rd_chk(5'h1C, 32'h0, '1);
   endtask

   task automatic t_gated;
      wr_reg(TCP_A_PERIOD, 32'h5);
      start(ctl(MODE_GATED, CMP_LT, 2'h0, 3'h1, 1'b0));
      rd_chk(TCP_A_COUNT, 32'h5, '1);
      fab.enable_for(2);
      rd_chk(TCP_A_COUNT, 32'h3, '1);
      fab.enable_for(3);
      #1 check(tc_out, 1'b1);
      rd_chk(TCP_A_STAT, 32'h1, 32'h1);
      check(irq_req, 1'b1);
      fab.enable_for(1);
      #1 check(tc_out, 1'b0);
      rd_chk(TCP_A_COUNT, 32'h5, '1);
      fab.enable_for(2);
      fab.pulse_reset();
      rd_chk(TCP_A_COUNT, 32'h5, '1);
   endtask

   task automatic t_oneshot;
      wr_reg(TCP_A_PERIOD, 32'h2);
      start(ctl(MODE_ONESHOT, CMP_LT, 2'h0, 3'h0, 1'b0));
      repeat (10) @(posedge clk);
      rd_chk(TCP_A_COUNT, 32'h0, '1);
      repeat (6) @(posedge clk);
      rd_chk(TCP_A_COUNT, 32'h0, '1);
   endtask

   // count held at 5 while the compare value steps across it
   task automatic t_compare;
      wr_reg(TCP_A_PERIOD, 32'h5);
      start(ctl(MODE_GATED, CMP_LT, 2'h0, 3'h0, 1'b0));
      for (int v = 4; v <= 6; v++) begin
         for (int k = 0; k < 5; k++) begin
            wr_reg(TCP_A_CMP, 32'(v));
            wr_reg(TCP_A_CTRL, ctl(MODE_GATED, tcp_cmp_t'(k), 2'h0, 3'h0, 1'b0));
            repeat (6) @(posedge clk);
            e = (k == 0) ? (5 < v) : (k == 1) ? (5 <= v) : (k == 2) ? (5 == v) : (k == 3) ? (5 >= v) : (5 > v);
            #1 check(cmp_out, e);
            check(cmp_n_out, !e);
         end
      end
      wr_reg(TCP_A_CTRL, ctl(MODE_GATED, CMP_LTE, 2'h0, 3'h0, 1'b0));
      repeat (6) @(posedge clk);
      fab.set_kill(1'b1);
      repeat (2) @(posedge clk);
      #1 check({cmp_out, cmp_n_out}, 32'h0);
      fab.set_kill(1'b0);
   endtask

   // both outputs low for the dead time, never both high
   task automatic t_dead;
      wr_reg(TCP_A_DEAD, 32'h4);
      repeat (8) @(posedge clk);
      wr_reg(TCP_A_CTRL, ctl(MODE_GATED, CMP_GT, 2'h0, 3'h0, 1'b0));
      gap = 0;
      repeat (20) begin
         @(posedge clk);
         #1 check(cmp_out & cmp_n_out, 1'b0);
         if (!cmp_out && !cmp_n_out) begin
            gap++;
         end
      end
      check(cmp_n_out, 1'b1);
      check(gap >= 5 && gap <= 6, 1'b1);
   endtask

   task automatic t_capture;
      wr_reg(TCP_A_CMP, 32'h0);
      wr_reg(TCP_A_PERIOD, 32'hA5C3);
      start(ctl(MODE_GATED, CMP_EQ, 2'h0, 3'h4, 1'b1));
      wr_reg(TCP_A_STAT, 32'h7);
      fab.enable_for(3);
      fab.pulse_capture();
      repeat (3) @(posedge clk);
      rd_chk(TCP_A_CAPT, 32'h0000A5C0, '1);
      rd_chk(TCP_A_STAT, 32'h4, 32'h4);
      check(irq_req, 1'b1);
      wr_reg(TCP_A_CTRL, ctl(MODE_GATED, CMP_EQ, 2'h0, 3'h1, 1'b1));
      repeat (2) @(posedge clk);
      #1 check(irq_req, 1'b0);
      wr_reg(TCP_A_STAT, 32'h4);
      rd_chk(TCP_A_STAT, 32'h0, 32'h4);
   endtask

   // only edges of the selected source may count
   task automatic t_source;
      wr_reg(TCP_A_PERIOD, 32'h64);
      start(ctl(MODE_FREE, CMP_LT, 2'h2, 3'h0, 1'b0));
      fab.src_edges(0, 5);
      fab.src_edges(1, 7);
      repeat (4) @(posedge clk);
      rd_chk(TCP_A_COUNT, 32'h5D, '1);
   endtask

   // a low clock enable freezes counting and ignores the bus
   task automatic t_freeze;
      wr_reg(TCP_A_PERIOD, 32'h20);
      start(ctl(MODE_FREE, CMP_LT, 2'h3, 3'h0, 1'b0));
      fab.src_edges(2, 4);
      repeat (2) @(posedge clk);
      rd_chk(TCP_A_COUNT, 32'h1C, '1);
      @(posedge clk) ce <= 1'b0;
      fab.src_edges(2, 3);
      wr_reg(TCP_A_PERIOD, 32'h7);
      @(posedge clk) ce <= 1'b1;
      rd_chk(TCP_A_COUNT, 32'h1C, '1);
      rd_chk(TCP_A_PERIOD, 32'h20, '1);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rstn  = 1'b0;
      ce    = 1'b1;
      wr    = 1'b0;
      rd    = 1'b0;
      addr  = '0;
      wdata = '0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_gated();
      t_oneshot();
      t_compare();
      t_dead();
      t_capture();
      t_source();
      t_freeze();
      test_done();
   end
endmodule
